// File: logic/tgrl_defs.vh
// Purpose: Constants for the transmit gap rate limiter
// Assumes: 32-bit register port, byte addresses in steps of 4
// Notes: Offsets are byte addresses
`ifndef TGRL_DEFS_VH
`define TGRL_DEFS_VH
`define TGRL_ADDR_PORT_MAC_CONFIG 8'h00
`define TGRL_ADDR_AGED 8'h04
`define TGRL_ADDR_MODE 8'h08
`define TGRL_ADDR_HDR 8'h0C
`define TGRL_ADDR_OVH 8'h10
`define TGRL_ADDR_RATIO 8'h14
`define TGRL_ADDR_START 8'h18
`define TGRL_ADDR_STICKY 8'h1C
`define TGRL_ADDR_PORT_SEL 8'h20
`define TGRL_MAC_HDX_BIT 0
`define TGRL_MAC_AGE_BIT 1
`define TGRL_MODE_OVH_BIT 0
`define TGRL_MODE_PAY_BIT 1
`define TGRL_MODE_FRM_BIT 2
`define TGRL_MODE_SUM_BIT 3
`define TGRL_MODE_PRE_BIT 4
`define TGRL_MODE_HDR_BIT 5
`define TGRL_MODE_SCALE_LSB 8
`define TGRL_STD_GAP 24'h00_000C
`define TGRL_FRM_THRESH 24'h00_000C
`define TGRL_PREAMBLE_BYTES 16'h0008
`define TGRL_RATIO_RESET 20'h0_0480
`endif

// File: logic/tgrl_limiter.v
// Purpose: Per-port transmit inter-packet gap stretching, aging and backpressure
// Assumes: Byte stream with sop/eop from the queue side, one byte per cycle
// Notes: Ports share the datapath; only one port's frame, taken from in_port at sop, runs at a time
//
// The implementer's own choices: the plain strobed port and the address map.
`include "tgrl_defs.vh"
`default_nettype none
module tgrl_limiter #(
  parameter PORTS = 4,
  parameter PW = 2
) (
  input wire ref_clk,
  input wire srst,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire [PW-1:0] in_port,
  input wire in_valid,
  input wire in_sop,
  input wire in_eop,
  input wire [7:0] in_data,
  input wire in_stuck,
  input wire in_era_aged,
  output wire in_ready,
  output reg out_valid,
  output reg out_sop,
  output reg out_eop,
  output reg [7:0] out_data,
  output reg [PW-1:0] out_port,
  output wire out_idle,
  input wire [PORTS-1:0] fc_status,
  output wire [PORTS-1:0] fdx_pause_req,
  output wire [PORTS-1:0] hdx_collide_req
);
  localparam ST_IDLE = 3'b001;
  localparam ST_FRAME = 3'b010;
  localparam ST_GAP = 3'b100;
  reg [2:0] st_q;
  reg [PW-1:0] sel_q;
  reg [PW-1:0] cur_q;
  reg [15:0] hdr_len_q;
  reg [PORTS-1:0] hdx_q;
  reg [PORTS-1:0] age_q;
  reg [PORTS-1:0] sticky_q;
  reg [15:0] mode_q [0:PORTS-1];
  reg [31:0] aged_q [0:PORTS-1];
  reg [7:0] ovh_q [0:PORTS-1];
  reg [19:0] ratio_q [0:PORTS-1];
  reg [23:0] start_q [0:PORTS-1];
  reg [19:0] frac_q [0:PORTS-1];
  reg [15:0] bytes_q;
  reg [15:0] paylen_q;
  reg [23:0] frm_cnt_q;
  reg dropping_q;
  reg [23:0] gap_cnt_q;
  wire [15:0] cmode;
  wire [3:0] scale;
  wire pre_pay;
  wire hdr_ex;
  wire [15:0] pre_off;
  wire [15:0] pay_start;
  wire is_pay;
  wire [15:0] len_final;
  wire [47:0] num;
  wire [47:0] quo;
  wire [47:0] rem;
  wire [23:0] pay_gap;
  wire [23:0] ovh_gap;
  wire [23:0] frm_gap;
  wire [23:0] frm_left;
  reg [23:0] extra;
  wire age_hit;
  wire [15:0] nmode;
  wire sop_pay;
  integer i;
  assign cmode = mode_q[cur_q];
  assign scale = cmode[`TGRL_MODE_SCALE_LSB+3:`TGRL_MODE_SCALE_LSB];
  assign pre_pay = cmode[`TGRL_MODE_PRE_BIT];
  assign hdr_ex = cmode[`TGRL_MODE_HDR_BIT];
  assign pre_off = pre_pay ? 16'h0000 : `TGRL_PREAMBLE_BYTES;
  assign pay_start = pre_off + (hdr_ex ? hdr_len_q : 16'h0000);
  assign is_pay = (st_q == ST_FRAME) && in_valid && (bytes_q >= pay_start) && !dropping_q;
  assign len_final = paylen_q + (is_pay ? 16'h0001 : 16'h0000);
  // sop byte is payload when nothing is skipped
  assign nmode = mode_q[in_port];
  assign sop_pay = nmode[`TGRL_MODE_PRE_BIT] && (!nmode[`TGRL_MODE_HDR_BIT] || hdr_len_q == 16'h0000);
  assign num = (({32'h0000_0000, len_final} << 8) << scale) + {28'h000_0000, frac_q[cur_q]};
  assign quo = (ratio_q[cur_q] == 20'h0_0000) ? 48'h0000_0000_0000 : num / ratio_q[cur_q];
  assign rem = (ratio_q[cur_q] == 20'h0_0000) ? 48'h0000_0000_0000 : num % ratio_q[cur_q];
  assign pay_gap = cmode[`TGRL_MODE_PAY_BIT] ? quo[23:0] : 24'h00_0000;
  assign ovh_gap = cmode[`TGRL_MODE_OVH_BIT] ? ({16'h0000, ovh_q[cur_q]} << scale) : 24'h00_0000;
  assign frm_left = frm_cnt_q - (is_pay ? 24'h00_0001 : 24'h00_0000);
  assign frm_gap = (cmode[`TGRL_MODE_FRM_BIT] && frm_left > `TGRL_FRM_THRESH) ?
    frm_left : 24'h00_0000;
  always @* begin
    if (cmode[`TGRL_MODE_SUM_BIT] && !cmode[`TGRL_MODE_FRM_BIT]) begin
      extra = ovh_gap + pay_gap;
    end else begin
      extra = (ovh_gap > pay_gap) ? ovh_gap : pay_gap;
      if (frm_gap > extra) begin
        extra = frm_gap;
      end
    end
  end
  assign age_hit = age_q[in_port] && (in_stuck || in_era_aged);
  assign in_ready = (st_q != ST_GAP);
  assign out_idle = (st_q == ST_GAP);
  assign hdx_collide_req = fc_status & hdx_q;
  assign fdx_pause_req = fc_status & ~hdx_q;
  always @(posedge ref_clk) begin
    if (srst) begin
      st_q <= ST_IDLE;
      sel_q <= {PW{1'b0}};
      cur_q <= {PW{1'b0}};
      hdr_len_q <= 16'h0000;
      hdx_q <= {PORTS{1'b0}};
      age_q <= {PORTS{1'b0}};
      sticky_q <= {PORTS{1'b0}};
      bytes_q <= 16'h0000;
      paylen_q <= 16'h0000;
      frm_cnt_q <= 24'h00_0000;
      dropping_q <= 1'b0;
      gap_cnt_q <= 24'h00_0000;
      out_valid <= 1'b0;
      out_sop <= 1'b0;
      out_eop <= 1'b0;
      out_data <= 8'h00;
      out_port <= {PW{1'b0}};
      reg_rdata <= 32'h0000_0000;
      for (i = 0; i < PORTS; i = i + 1) begin
        mode_q[i] <= 16'h0000;
        aged_q[i] <= 32'h0000_0000;
        ovh_q[i] <= 8'h00;
        ratio_q[i] <= `TGRL_RATIO_RESET;
        start_q[i] <= 24'h00_0000;
        frac_q[i] <= 20'h0_0000;
      end
    end else begin
      reg_rdata <= 32'h0000_0000;
      if (reg_rd) begin
        case (reg_addr)
          `TGRL_ADDR_PORT_MAC_CONFIG: reg_rdata <= {30'h0000_0000, age_q[sel_q], hdx_q[sel_q]};
          `TGRL_ADDR_AGED: reg_rdata <= aged_q[sel_q];
          `TGRL_ADDR_MODE: reg_rdata <= {16'h0000, mode_q[sel_q]};
          `TGRL_ADDR_HDR: reg_rdata <= {16'h0000, hdr_len_q};
          `TGRL_ADDR_OVH: reg_rdata <= {24'h00_0000, ovh_q[sel_q]};
          `TGRL_ADDR_RATIO: reg_rdata <= {12'h000, ratio_q[sel_q]};
          `TGRL_ADDR_START: reg_rdata <= {8'h00, start_q[sel_q]};
          `TGRL_ADDR_STICKY: reg_rdata <= {31'h0000_0000, sticky_q[sel_q]};
          `TGRL_ADDR_PORT_SEL: reg_rdata <= {{(32-PW){1'b0}}, sel_q};
          default: reg_rdata <= 32'h0000_0000;
        endcase
      end
      if (reg_wr) begin
        case (reg_addr)
          `TGRL_ADDR_PORT_MAC_CONFIG: begin
            hdx_q[sel_q] <= reg_wdata[`TGRL_MAC_HDX_BIT];
            age_q[sel_q] <= reg_wdata[`TGRL_MAC_AGE_BIT];
          end
          `TGRL_ADDR_MODE: mode_q[sel_q] <= {4'h0, reg_wdata[11:8], 2'b00, reg_wdata[5:0]};
          `TGRL_ADDR_HDR: hdr_len_q <= reg_wdata[15:0];
          `TGRL_ADDR_OVH: ovh_q[sel_q] <= reg_wdata[7:0];
          `TGRL_ADDR_RATIO: ratio_q[sel_q] <= reg_wdata[19:0];
          `TGRL_ADDR_START: start_q[sel_q] <= reg_wdata[23:0];
          `TGRL_ADDR_PORT_SEL: sel_q <= reg_wdata[PW-1:0];
          default: begin
          end
        endcase
      end
      // Write-one-to-clear; a new set in the same cycle is applied after and wins
      if (reg_wr && reg_addr == `TGRL_ADDR_STICKY && reg_wdata[0]) begin
        sticky_q[sel_q] <= 1'b0;
      end
      out_valid <= 1'b0;
      out_sop <= 1'b0;
      out_eop <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (in_valid && in_sop) begin
            cur_q <= in_port;
            bytes_q <= 16'h0001;
            paylen_q <= sop_pay ? 16'h0001 : 16'h0000;
            frm_cnt_q <= start_q[in_port] - (sop_pay ? 24'h00_0001 : 24'h00_0000);
            dropping_q <= age_hit;
            if (age_hit) begin
              aged_q[in_port] <= aged_q[in_port] + 32'h0000_0001;
            end else begin
              out_valid <= 1'b1;
              out_sop <= 1'b1;
              out_eop <= in_eop;
              out_data <= in_data;
              out_port <= in_port;
            end
            if (in_eop) begin
              st_q <= age_hit ? ST_IDLE : ST_GAP;
              gap_cnt_q <= `TGRL_STD_GAP;
            end else begin
              st_q <= ST_FRAME;
            end
          end
        end
        ST_FRAME: begin
          if (in_valid) begin
            bytes_q <= bytes_q + 16'h0001;
            if (is_pay) begin
              paylen_q <= len_final;
              frm_cnt_q <= frm_left;
            end
            if (!dropping_q) begin
              out_valid <= 1'b1;
              out_data <= in_data;
              out_port <= cur_q;
              out_eop <= in_eop;
            end
            if (in_eop) begin
              if (dropping_q) begin
                st_q <= ST_IDLE;
              end else begin
                st_q <= ST_GAP;
                gap_cnt_q <= `TGRL_STD_GAP + extra;
                if (cmode[`TGRL_MODE_PAY_BIT]) begin
                  frac_q[cur_q] <= rem[19:0];
                end
                if (extra != 24'h00_0000) begin
                  sticky_q[cur_q] <= 1'b1;
                end
              end
            end
          end
        end
        ST_GAP: begin
          if (gap_cnt_q <= 24'h00_0001) begin
            st_q <= ST_IDLE;
          end else begin
            gap_cnt_q <= gap_cnt_q - 24'h00_0001;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end
endmodule // tgrl_limiter
`default_nettype wire

// File: bench/tgrl_props.sv
// Purpose: Port checker for tgrl_limiter
// Assumes: Bound to the top module, one clock
// Notes: Extra gap lengths are judged in the bench
`default_nettype none
module tgrl_props #(
  parameter PORTS = 4,
  parameter PW = 2
) (
  input wire ref_clk,
  input wire srst,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  input wire [PW-1:0] in_port,
  input wire in_valid,
  input wire in_sop,
  input wire [7:0] in_data,
  input wire in_ready,
  input wire out_valid,
  input wire out_sop,
  input wire out_eop,
  input wire [7:0] out_data,
  input wire [PW-1:0] out_port,
  input wire [PORTS-1:0] fc_status,
  input wire [PORTS-1:0] fdx_pause_req,
  input wire [PORTS-1:0] hdx_collide_req
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  property p_fc_split; (fdx_pause_req | hdx_collide_req) == fc_status; endproperty
  a_fc_split: assert property (p_fc_split) else $error("fc lost");
  property p_fc_one; (fdx_pause_req & hdx_collide_req) == '0; endproperty
  a_fc_one: assert property (p_fc_one) else $error("fc both ways");
  property p_out_src; out_valid |-> $past(in_valid && in_ready); endproperty
  a_out_src: assert property (p_out_src) else $error("byte from nowhere");
  property p_out_dat; out_valid |-> out_data == $past(in_data) && out_port == $past(in_port);
  endproperty
  a_out_dat: assert property (p_out_dat) else $error("byte altered");
  property p_out_sop; out_sop |-> out_valid && $past(in_sop); endproperty
  a_out_sop: assert property (p_out_sop) else $error("sop moved");
  // A 12 cycle floor, split because repetition tops out at 8
  property p_gap_min; out_eop |-> !in_ready [*8] ##1 !in_ready [*4]; endproperty
  a_gap_min: assert property (p_gap_min) else $error("gap short");
  property p_gap_end; $fell(in_ready) |-> ##[12:1000] in_ready; endproperty
  a_gap_end: assert property (p_gap_end) else $error("gap hangs");
  property p_rd_quiet; reg_rdata != '0 |-> $past(reg_rd); endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("stray read data");
  c_gap: cover property ($fell(in_ready));
  c_eop: cover property (out_eop);
  c_hdx: cover property (hdx_collide_req != '0);
endmodule // tgrl_props
bind tgrl_limiter tgrl_props #(.PORTS(PORTS), .PW(PW)) tgrl_props_i (.ref_clk, .srst,
  .reg_rd, .reg_rdata, .in_port, .in_valid, .in_sop, .in_data, .in_ready, .out_valid,
  .out_sop, .out_eop, .out_data, .out_port, .fc_status, .fdx_pause_req, .hdx_collide_req);
`default_nettype wire

// File: bench/tgrl_src.sv
// Purpose: Queue-side frame source
// Assumes: Called when in_ready is high
// Notes: Released data toggles so a stale byte never looks valid
`default_nettype none
module tgrl_src (
  input wire logic ref_clk,
  input wire logic in_ready,
  output var logic [1:0] in_port,
  output var logic in_valid,
  output var logic in_sop,
  output var logic in_eop,
  output var logic [7:0] in_data,
  output var logic in_stuck,
  output var logic in_era_aged
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {in_port, in_valid, in_sop, in_eop, in_data, in_stuck, in_era_aged} = '0;
  end
  task automatic send(input logic [1:0] p, input int n, input logic st, input logic era);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      in_port <= p;
      in_valid <= 1'b1;
      in_sop <= (i == 0);
      in_eop <= (i == n - 1);
      in_data <= 8'(i) ^ 8'h5A;
      in_stuck <= st;
      in_era_aged <= era;
    end
    @(posedge ref_clk);
    in_valid <= 1'b0;
    in_data <= ~in_data;
  endtask
endmodule // tgrl_src
`default_nettype wire

// File: bench/tx_gap_rate_limiter_tb_top.sv
// Purpose: Register and gap tests for tgrl_limiter
// Assumes: Port 0 selected unless stated
// Notes: Gap is the count of cycles with in_ready low
`default_nettype none
module tx_gap_rate_limiter_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic [3:0] fc_status = 4'h0;
  logic [31:0] reg_rdata;
  logic [1:0] in_port, out_port;
  logic in_valid, in_sop, in_eop, in_stuck, in_era_aged, in_ready;
  logic out_valid, out_sop, out_eop, out_idle;
  logic [7:0] in_data, out_data;
  logic [3:0] fdx_pause_req, hdx_collide_req;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  int n_sop = 0;
  int k;
  tgrl_limiter tgrl_limiter_i (.ref_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .in_port, .in_valid, .in_sop, .in_eop, .in_data, .in_stuck, .in_era_aged,
    .in_ready, .out_valid, .out_sop, .out_eop, .out_data, .out_port, .out_idle, .fc_status,
    .fdx_pause_req, .hdx_collide_req);
  tgrl_src tgrl_src_i (.ref_clk, .in_ready, .in_port, .in_valid, .in_sop, .in_eop,
    .in_data, .in_stuck, .in_era_aged);
  always #25 ref_clk = ~ref_clk;
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (out_sop === 1'b1) begin
      n_sop++;
    end
    if (cyc == 20000) begin
      n_fail++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // Mode, overhead, ratio, start; software keeps them in range
  task automatic cfg(input logic [11:0] m, input logic [7:0] o, input logic [19:0] r,
    input logic [7:0] s);
    wr(8'h10, 32'(o));
    wr(8'h14, 32'(r));
    wr(8'h18, 32'(s));
    wr(8'h08, 32'(m));
  endtask
  task automatic frm(input logic [1:0] p, input int g);
    int c = 0;
    tgrl_src_i.send(p, 20, 1'b0, 1'b0);
    @(negedge ref_clk);
    chk(32'(out_idle), 32'h0000_0001);
    while (in_ready !== 1'b1 && c < 2000) begin
      c++;
      @(negedge ref_clk);
    end
    chk(c, g);
    $display("gap test %0d done", g);
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    rd(8'h14, 32'h0000_0480);
    rd(8'h40, 32'h0000_0000);
    wr(8'h04, 32'h0000_0055);
    rd(8'h04, 32'h0000_0000);
    frm(2'd0, 12);
    cfg(12'h001, 8'h14, 20'h0_0480, 8'h00);
    frm(2'd0, 32);
    rd(8'h1C, 32'h0000_0001);
    cfg(12'h004, 8'h14, 20'h0_0480, 8'h28);
    frm(2'd0, 40);
    wr(8'h08, 32'h0000_0014);
    frm(2'd0, 32);
    wr(8'h0C, 32'h0000_0004);
    wr(8'h08, 32'h0000_0024);
    frm(2'd0, 44);
    cfg(12'h014, 8'h14, 20'h0_0480, 8'h20);
    frm(2'd0, 12);
    cfg(12'h005, 8'h14, 20'h0_0480, 8'h28);
    frm(2'd0, 40);
    cfg(12'h302, 8'h14, 20'h0_0800, 8'h00);
    frm(2'd0, 24);
    wr(8'h08, 32'h0000_0303);
    frm(2'd0, 172);
    wr(8'h08, 32'h0000_030B);
    frm(2'd0, 184);
    cfg(12'h002, 8'h14, 20'h0_1000, 8'h00);
    frm(2'd0, 12);
    frm(2'd0, 13);
    wr(8'h20, 32'h0000_0001);
    frm(2'd1, 12);
    cfg(12'h024, 8'h00, 20'h0_0480, 8'h28);
    frm(2'd1, 44);
    wr(8'h20, 32'h0000_0000);
    frm(2'd0, 13);
    wr(8'h08, 32'h0000_0000);
    wr(8'h00, 32'h0000_0002);
    k = n_sop;
    tgrl_src_i.send(2'd0, 20, 1'b1, 1'b0);
    repeat (40) @(posedge ref_clk);
    tgrl_src_i.send(2'd0, 20, 1'b0, 1'b1);
    repeat (40) @(posedge ref_clk);
    chk(n_sop, k);
    rd(8'h04, 32'h0000_0002);
    fc_status <= 4'h5;
    wr(8'h00, 32'h0000_0001);
    @(negedge ref_clk);
    chk(hdx_collide_req, 4'h1);
    chk(fdx_pause_req, 4'h4);
    $display("aging and backpressure tests done");
    test_done();
  end
endmodule // tx_gap_rate_limiter_tb_top
`default_nettype wire
